// ### design/cmcs_pkg.sv
`default_nettype none

package cmcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // Silence on a master clock pin longer than this means not toggling
  localparam int ACT_WIN_NS    = 1000;
  localparam int ACT_WIN_CYC   = (ACT_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          AXI_AW    = 8;
  localparam logic [7:0]  ADDR_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_STAT = 8'h04;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

  localparam int CTRL_TTS_LSB  = 0;
  localparam int CTRL_DRV_VAL  = 8;
  localparam int CTRL_DRV_EN   = 9;

  localparam int STAT_LOS_LSB  = 0;
  localparam int STAT_HW_BIT   = 8;
  localparam int STAT_SPI_BIT  = 9;
  localparam int STAT_SRC_LSB  = 10;
  localparam int STAT_ACT_LSB  = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Pin sync vector layout
  // ----------------------------------------------------------------
  localparam int PIN_MODE = 0;
  localparam int PIN_BSS  = 1;
  localparam int PIN_RD   = 2;
  localparam int PIN_WR   = 3;
  localparam int PIN_TTS  = 4;

  // ----------------------------------------------------------------
  // DS3 master clock source
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_DS3_MCLK,
    SRC_SYNTH_E3,
    SRC_SYNTH_STS1,
    SRC_TX_LINE
  } cmcs_src_e;

endpackage

`default_nettype wire

// ### design/cmcs_act_det.sv
`default_nettype none

module cmcs_act_det
  import cmcs_pkg::*;
#(
  parameter int WIN = ACT_WIN_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic smp,
  output var  logic active_r,
  output var  logic level_r
);

  localparam int CW = $clog2(WIN + 1);

  if (WIN < 2) begin : g_bad_win
    $error("cmcs_act_det: WIN must be at least 2");
  end

  logic          prev_r;
  logic [CW-1:0] cnt_r;
  wire           edge_seen = smp ^ prev_r;
  wire           expired   = (cnt_r == CW'(WIN - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      // Track the pin in reset so a high pin gives no false edge after
      prev_r   <= smp;
      cnt_r    <= '0;
      active_r <= 1'b0;
      level_r  <= smp;
    end else begin
      prev_r  <= smp;
      level_r <= smp;
      if (edge_seen) begin
        cnt_r    <= '0;
        active_r <= 1'b1;
      end else if (!expired) begin
        cnt_r <= cnt_r + CW'(1);
      end else begin
        active_r <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### design/cmcs_top.sv
// Operation
// - Strap high selects hardware pin mode
// - Hardware mode refuses all register access
// - Strap low enters CPU bus mode
// - CPU mode defaults to parallel interface
// - Serial only when style, read, write low
// - Register bits active high, pins may invert
// - Some pins stay live in both modes
// - Live config is pin OR register bit
// - Present DS3 master clock drives DS3 ports
// - DS3 pin low: synthesize from E3, STS-1
// - DS3 pin high: ports use transmit clock
// - No alternate clocks: fall back to transmit clock
// - DS3 clock pin bidirectional only in CPU mode
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`default_nettype none

module cmcs_top
  import cmcs_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 mode_strap,
  input  wire logic                 bus_style_select,
  input  wire logic                 rd_n,
  input  wire logic                 wr_n,
  input  wire logic [NUM_PORTS-1:0] tx_driver_tristate_n,
  input  wire logic                 ds3_master_clk_in,
  input  wire logic                 e3_master_clk_in,
  input  wire logic                 sts1_master_clk_in,
  input  wire logic [NUM_PORTS-1:0] rx_los,
  output var  logic                 ds3_master_clk_out,
  output var  logic                 ds3_master_clk_oe,
  output var  logic [NUM_PORTS-1:0] rx_loss_of_signal_n,
  output var  logic [NUM_PORTS-1:0] tx_tristate_eff,
  output var  logic                 hw_mode,
  output var  logic                 spi_enable,
  output var  logic                 parallel_enable,
  output var  cmcs_src_e            ds3_mclk_src,
  input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  localparam int SYNC_W  = PIN_TTS + NUM_PORTS + 3;
  localparam int PIN_MCK = PIN_TTS + NUM_PORTS;

  // Tristate bits must fit byte lane 0 of the control word
  if (NUM_PORTS < 1 || NUM_PORTS > 8) begin : g_bad_ports
    $error("cmcs_top: NUM_PORTS must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;
  wire  [SYNC_W-1:0] pin_raw = {sts1_master_clk_in, e3_master_clk_in, ds3_master_clk_in,
                                tx_driver_tristate_n, wr_n, rd_n, bus_style_select,
                                mode_strap};

  // No reset: the capture edge after release must see settled straps
  always_ff @(posedge clk) begin
    pin_meta_r <= pin_raw;
    pin_sync_r <= pin_meta_r;
  end

  wire                 mode_s = pin_sync_r[PIN_MODE];
  wire                 spi_s  = ~pin_sync_r[PIN_BSS] & ~pin_sync_r[PIN_RD] & ~pin_sync_r[PIN_WR];
  wire [NUM_PORTS-1:0] tts_n_s = pin_sync_r[PIN_TTS +: NUM_PORTS];

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps are read once after reset; later pin motion is ignored
  logic taken_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      taken_r         <= 1'b0;
      hw_mode         <= 1'b1;
      spi_enable      <= 1'b0;
      parallel_enable <= 1'b0;
    end else if (!taken_r) begin
      taken_r         <= 1'b1;
      hw_mode         <= mode_s;
      spi_enable      <= ~mode_s & spi_s;
      parallel_enable <= ~mode_s & ~spi_s;
    end
  end

  // ----------------------------------------------------------------
  // Master clock activity
  // ----------------------------------------------------------------
  logic [2:0] mck_act;
  logic [2:0] mck_lvl;

  for (genvar i = 0; i < 3; i++) begin : g_act
    cmcs_act_det #(
      .WIN (ACT_WIN_CYC)
    ) u_det (
      .clk      (clk),
      .reset    (reset),
      .smp      (pin_sync_r[PIN_MCK + i]),
      .active_r (mck_act[i]),
      .level_r  (mck_lvl[i])
    );
  end

  // Held high beats the alternates: the pin level is a deliberate choice
  cmcs_src_e src_nxt;
  assign src_nxt = mck_act[0] ? SRC_DS3_MCLK :
                   mck_lvl[0] ? SRC_TX_LINE :
                   mck_act[1] ? SRC_SYNTH_E3 :
                   mck_act[2] ? SRC_SYNTH_STS1 :
                                SRC_TX_LINE;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] ctrl_tts_r;
  logic                 ctrl_drv_val_r;
  logic                 ctrl_drv_en_r;

  logic              aw_held_r;
  logic              w_held_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;

  wire              aw_hs   = s_axi_awvalid & s_axi_awready;
  wire              w_hs    = s_axi_wvalid & s_axi_wready;
  wire              aw_have = aw_held_r | aw_hs;
  wire              w_have  = w_held_r | w_hs;
  wire              wr_go   = aw_have & w_have & ~s_axi_bvalid;
  wire [AXI_AW-1:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0]       wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0]        wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire              bvalid_nxt  = wr_go | (s_axi_bvalid & ~s_axi_bready);
  wire              aw_held_nxt = aw_have & ~wr_go;
  wire              w_held_nxt  = w_have & ~wr_go;

  wire wr_ctrl   = wr_go & ~hw_mode & (wr_addr == ADDR_CTRL);
  wire wr_mapped = (wr_addr == ADDR_CTRL) | (wr_addr == ADDR_STAT);
  wire [1:0] wr_resp = hw_mode    ? RESP_SLVERR :
                       wr_mapped  ? RESP_OKAY :
                                    RESP_DECERR;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_held_r     <= aw_held_nxt;
      w_held_r      <= w_held_nxt;
      s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_held_nxt & ~bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bresp <= wr_resp;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_tts_r     <= CTRL_RST[CTRL_TTS_LSB +: NUM_PORTS];
      ctrl_drv_val_r <= CTRL_RST[CTRL_DRV_VAL];
      ctrl_drv_en_r  <= CTRL_RST[CTRL_DRV_EN];
    end else if (wr_ctrl) begin
      if (wr_strb[0]) begin
        ctrl_tts_r <= wr_data[CTRL_TTS_LSB +: NUM_PORTS];
      end
      if (wr_strb[1]) begin
        ctrl_drv_val_r <= wr_data[CTRL_DRV_VAL];
        ctrl_drv_en_r  <= wr_data[CTRL_DRV_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire ar_hs      = s_axi_arvalid & s_axi_arready;
  wire rvalid_nxt = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire rd_is_ctrl = (s_axi_araddr == ADDR_CTRL);
  wire rd_is_stat = (s_axi_araddr == ADDR_STAT);

  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_TTS_LSB +: NUM_PORTS] = ctrl_tts_r;
    ctrl_word[CTRL_DRV_VAL] = ctrl_drv_val_r;
    ctrl_word[CTRL_DRV_EN]  = ctrl_drv_en_r;
    stat_word = '0;
    stat_word[STAT_LOS_LSB +: NUM_PORTS] = rx_los;
    stat_word[STAT_HW_BIT]  = hw_mode;
    stat_word[STAT_SPI_BIT] = spi_enable;
    stat_word[STAT_SRC_LSB +: 2] = ds3_mclk_src;
    stat_word[STAT_ACT_LSB +: 3] = mck_act;
  end

  wire [31:0] rd_word = hw_mode    ? 32'h0000_0000 :
                        rd_is_ctrl ? ctrl_word :
                        rd_is_stat ? stat_word :
                                     32'h0000_0000;
  wire [1:0]  rd_resp = hw_mode                   ? RESP_SLVERR :
                        (rd_is_ctrl | rd_is_stat) ? RESP_OKAY :
                                                    RESP_DECERR;

  logic rd_stat_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
      rd_stat_r     <= 1'b0;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
        rd_stat_r   <= rd_is_stat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins live in both modes, clock select
  // ----------------------------------------------------------------
  wire [NUM_PORTS-1:0] tts_nxt = ~tts_n_s | (ctrl_tts_r & {NUM_PORTS{~hw_mode}});

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_loss_of_signal_n <= '1;
      tx_tristate_eff     <= '0;
      ds3_mclk_src        <= SRC_TX_LINE;
      ds3_master_clk_out  <= 1'b0;
      ds3_master_clk_oe   <= 1'b0;
    end else begin
      rx_loss_of_signal_n <= ~rx_los;
      tx_tristate_eff     <= tts_nxt;
      ds3_mclk_src        <= src_nxt;
      ds3_master_clk_out  <= ctrl_drv_val_r;
      ds3_master_clk_oe   <= ~hw_mode & ctrl_drv_en_r;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_hw_strap_take: assert property ($rose(taken_r) |-> hw_mode == $past(mode_s))
    else $error("hw mode does not follow strap");
  a_hw_refuse_wr: assert property (hw_mode && s_axi_bvalid |-> s_axi_bresp == RESP_SLVERR)
    else $error("write accepted in hw mode");
  a_hw_refuse_rd: assert property (hw_mode && s_axi_rvalid |->
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("read accepted in hw mode");
  a_cpu_mode_iface: assert property ($rose(taken_r) && !hw_mode |->
      parallel_enable != spi_enable)
    else $error("cpu mode without one interface");
  a_parallel_default: assert property (taken_r && !hw_mode && !spi_enable |-> parallel_enable)
    else $error("parallel not default");
  a_spi_select: assert property ($rose(taken_r) && spi_enable |-> $past(spi_s))
    else $error("serial chosen without select");
  a_los_polarity: assert property ($rose(s_axi_rvalid) && rd_stat_r &&
      s_axi_rresp == RESP_OKAY |-> s_axi_rdata[NUM_PORTS-1:0] == ~rx_loss_of_signal_n)
    else $error("status bit polarity wrong");
  a_pin_both_modes: assert property ((~tts_n_s != '0) |=>
      (($past(~tts_n_s) & ~tx_tristate_eff) == '0))
    else $error("tristate pin ignored");
  a_tts_or: assert property (!hw_mode && (ctrl_tts_r != '0) ##1 $stable(ctrl_tts_r) |->
      ((ctrl_tts_r & ~tx_tristate_eff) == '0))
    else $error("tristate bit ignored");
  a_ds3_present: assert property (mck_act[0] |=> ds3_mclk_src == SRC_DS3_MCLK)
    else $error("present ds3 clock not used");
  a_synth_pref: assert property (!mck_act[0] && !mck_lvl[0] && mck_act[1] |=>
      ds3_mclk_src == SRC_SYNTH_E3)
    else $error("e3 not first choice");
  a_held_high: assert property (!mck_act[0] && mck_lvl[0] |=> ds3_mclk_src == SRC_TX_LINE)
    else $error("held high not tx clock");
  a_fallback: assert property (mck_act == 3'b000 && !mck_lvl[0] |=>
      ds3_mclk_src == SRC_TX_LINE)
    else $error("no fallback to tx clock");
  a_mclk_dir: assert property (hw_mode && $past(hw_mode) |-> !ds3_master_clk_oe)
    else $error("ds3 clock pin driven in hw mode");
  a_mode_static: assert property (taken_r ##1 taken_r |-> $stable(hw_mode) && $stable(spi_enable))
    else $error("mode changed in operation");
  a_ds3_drive_val: assert property (ds3_master_clk_oe |->
      ds3_master_clk_out == $past(ctrl_drv_val_r))
    else $error("ds3 clock pin drives wrong level");

  c_spi_mode: cover property ($rose(taken_r) && spi_enable);
  c_par_write: cover property (parallel_enable && s_axi_bvalid && s_axi_bresp == RESP_OKAY);
  c_sts1_synth: cover property (ds3_mclk_src == SRC_SYNTH_STS1);
  c_ds3_drive: cover property (ds3_master_clk_oe && ds3_master_clk_out);

endmodule

`default_nettype wire

// ### dv/cmcs_pin_partner.sv
`default_nettype none

module cmcs_pin_partner (
  input  wire logic       clk,
  input  wire logic [3:0] strap_cfg,
  input  wire logic [5:0] mclk_cfg,
  output var  logic       mode_strap,
  output var  logic       bus_style_select,
  output var  logic       rd_n,
  output var  logic       wr_n,
  output var  logic       ds3_pin,
  output var  logic       e3_pin,
  output var  logic       sts1_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_r = 2'h0;
  logic       tog_r = 1'b0;

  // ----------------------------------------------------------------
  // Straps and master clocks
  // ----------------------------------------------------------------
  // Straps only move while the bench holds reset
  assign {mode_strap, bus_style_select, rd_n, wr_n} = strap_cfg;

  // Per pin: 0 held low, 1 held high, 2 toggling at clk/8
  always_ff @(posedge clk) begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3)
      tog_r <= ~tog_r;
  end

  assign ds3_pin  = (mclk_cfg[5:4] == 2'h2) ? tog_r : mclk_cfg[4];
  assign e3_pin   = (mclk_cfg[3:2] == 2'h2) ? tog_r : mclk_cfg[2];
  assign sts1_pin = (mclk_cfg[1:0] == 2'h2) ? tog_r : mclk_cfg[0];
endmodule

`default_nettype wire

// ### dv/tb_top.sv
`default_nettype none

module tb_top
  import cmcs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  strap_cfg = 4'hf;
  logic [5:0]  mclk_cfg = 6'h20;
  logic [3:0]  tts_n = 4'hf;
  logic [3:0]  rx_los = 4'h0;
  logic        mode_strap, bss, rd_n, wr_n, ds3_pin, e3_pin, sts1_pin;
  logic        ds3_out, ds3_oe, ds3_wire, hw, spi, par;
  logic [3:0]  los_n, tts_eff;
  cmcs_src_e   src;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [5:0]  cfg_tab [5] = '{6'h20, 6'h0a, 6'h02, 6'h18, 6'h00};
  cmcs_src_e   src_tab [5] = '{SRC_DS3_MCLK, SRC_SYNTH_E3, SRC_SYNTH_STS1,
                               SRC_TX_LINE, SRC_TX_LINE};
  logic [2:0]  sel_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

  // Shared pin: design wins while it enables its driver
  assign ds3_wire = ds3_oe ? ds3_out : ds3_pin;

  initial forever #5 clk = ~clk;

  cmcs_pin_partner i_partner (
    .clk(clk), .strap_cfg(strap_cfg), .mclk_cfg(mclk_cfg),
    .mode_strap(mode_strap), .bus_style_select(bss), .rd_n(rd_n), .wr_n(wr_n),
    .ds3_pin(ds3_pin), .e3_pin(e3_pin), .sts1_pin(sts1_pin)
  );

  cmcs_top #(.NUM_PORTS(4)) i_dut (
    .clk(clk), .reset(reset), .mode_strap(mode_strap), .bus_style_select(bss),
    .rd_n(rd_n), .wr_n(wr_n), .tx_driver_tristate_n(tts_n),
    .ds3_master_clk_in(ds3_wire), .e3_master_clk_in(e3_pin),
    .sts1_master_clk_in(sts1_pin), .rx_los(rx_los),
    .ds3_master_clk_out(ds3_out), .ds3_master_clk_oe(ds3_oe),
    .rx_loss_of_signal_n(los_n), .tx_tristate_eff(tts_eff), .hw_mode(hw),
    .spi_enable(spi), .parallel_enable(par), .ds3_mclk_src(src),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Straps only change under reset, as a board would strap them
  task automatic rst(input logic [3:0] straps);
    @(posedge clk);
    reset <= 1'b1;
    strap_cfg <= straps;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Handshakes sampled at the falling edge, released after the taking edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      n++;
      if (n > 500) begin
        n_fail++;
        end_sim();
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int   n;
    logic ar, r;
    n = 0;
    r = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid && rready;
      resp = rresp;
      rd = rdata;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
      n++;
      if (n > 500) begin
        n_fail++;
        end_sim();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    rst(4'hf);
    chk(hw, 1'b1);
    chk(spi, 1'b0);
    axi_wr(ADDR_CTRL, 32'h0000_030f);
    chk(resp, RESP_SLVERR);
    repeat (4) @(posedge clk);
    chk(ds3_oe, 1'b0);
    chk(tts_eff, 4'h0);
    axi_rd(ADDR_STAT);
    chk(resp, RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    rx_los <= 4'h3;
    tts_n <= 4'he;
    repeat (5) @(posedge clk);
    chk(los_n, 4'hc);
    chk(tts_eff, 4'h1);
    for (int i = 0; i < 5; i++) begin
      mclk_cfg <= cfg_tab[i];
      repeat (2 * ACT_WIN_CYC + 8) @(posedge clk);
      chk(src, src_tab[i]);
    end
    rst(4'h7);
    chk(hw, 1'b0);
    chk(par, 1'b1);
    chk(spi, 1'b0);
    axi_wr(ADDR_CTRL, 32'h0000_0002);
    chk(resp, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk(tts_eff, 4'h3);
    axi_rd(ADDR_CTRL);
    chk(rd, 32'h0000_0002);
    axi_rd(ADDR_STAT);
    chk(rd[3:0], 4'h3);
    chk(rd, 32'h0000_0c03);
    chk(los_n, 4'hc);
    axi_rd(8'h10);
    chk(resp, RESP_DECERR);
    axi_wr(8'h10, 32'h0000_000f);
    chk(resp, RESP_DECERR);
    axi_wr(ADDR_CTRL, 32'h0000_0300);
    repeat (4) @(posedge clk);
    chk(ds3_oe, 1'b1);
    chk(ds3_out, 1'b1);
    chk(tts_eff, 4'h1);
    // Driven-high shared pin reads as held high, even with e3 toggling
    mclk_cfg <= 6'h08;
    repeat (2 * ACT_WIN_CYC + 8) @(posedge clk);
    chk(src, SRC_TX_LINE);
    for (int i = 0; i < 4; i++) begin
      rst({1'b0, sel_tab[i]});
      chk(spi, i == 0);
      chk(par, i != 0);
    end
    end_sim();
  end
endmodule

`default_nettype wire
